// ### design/user_feature_config_pkg.sv
// Package: command codes, field layout and reset values of the feature registers
package user_feature_config_pkg;

  localparam logic [7:0] CMD_USER_FEATURE_CONFIG = 8'hd1;
  localparam logic [7:0] CMD_INPUT_CURRENT_CAL_GAIN = 8'hd2;

  localparam logic [15:0] USER_FEATURE_CONFIG_RESET = 16'h0402;
  localparam logic [15:0] INPUT_CURRENT_CAL_GAIN_RESET = 16'hc200;

  localparam int MIN_DUTY_MSB = 15;
  localparam int MIN_DUTY_LSB = 11;
  localparam int DRIVER_STAGE_BIT = 10;
  localparam int MIN_DUTY_EN_BIT = 7;
  localparam int MARGIN_RATIO_EN_BIT = 4;
  localparam int PG_PUSH_PULL_BIT = 2;
  localparam int EXT_TEMP_EN_BIT = 1;
  localparam int EXT_TEMP_FAULT_BIT = 0;

  localparam int CAL_EXP_MSB = 15;
  localparam int CAL_EXP_LSB = 11;
  localparam int CAL_MANT_MSB = 10;

  // Duty is expressed in 1/512 steps
  localparam int DUTY_WIDTH = 9;

  typedef struct packed {
    logic [4:0] min_duty_code;
    logic driver_stage_mode;
    logic min_duty_en;
    logic margin_ratio_en;
    logic pg_push_pull;
    logic ext_temp_en;
    logic ext_temp_fault_sel;
  } feature_fields_type;

  typedef struct packed {
    logic signed [4:0] exponent;
    logic signed [10:0] mantissa;
  } linear11_type;

endpackage

// ### design/linear11_unpack.sv
// Module: splits a linear-11 word into signed exponent and mantissa
`timescale 1ns/1ps
module linear11_unpack (
  input wire logic [15:0] word,
  output user_feature_config_pkg::linear11_type fields
);

  // Value is mantissa times two to the exponent
  assign fields.exponent = $signed(word[user_feature_config_pkg::CAL_EXP_MSB:
                                        user_feature_config_pkg::CAL_EXP_LSB]); // [RQ10]
  assign fields.mantissa = $signed(word[user_feature_config_pkg::CAL_MANT_MSB:0]); // [RQ10]

endmodule

// ### design/user_feature_config_regs.sv
// Module: user feature and input-current calibration command registers
// Summary of operation
// [RQ1] Minimum duty equals two times (code+1) over 512
// [RQ2] Duty clamp acts only while bit 7 set
// [RQ3] Bit 10 clear: separate direct gate drives
// [RQ4] Bit 10 set: low enables stage, high is PWM
// [RQ5] Bit 4 selects margin-ratio levels for margining
// [RQ6] Bit 2: power-good open-drain or push-pull
// [RQ7] Bit 1 enables external temperature readout
// [RQ8] Bit 0 picks external sensor for faults
// [RQ9] Feature register 16-bit read/write, resets 0402h
// [RQ10] Cal gain is linear-11, signed exponent and mantissa
// [RQ11] Cal gain is the 25 C sense impedance
// [RQ12] Cal gain read/write, resets C200h, two milliohms
// [RQ13] Host writes zeros to unused bits
`timescale 1ns/1ps
module user_feature_config_regs #(
  parameter int TEMP_WIDTH = 16,
  parameter int MARGIN_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_wdata,
  input wire logic write_protect,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_unsupported,
  input wire logic [user_feature_config_pkg::DUTY_WIDTH-1:0] duty_request,
  output logic [user_feature_config_pkg::DUTY_WIDTH-1:0] duty_applied,
  input wire logic high_side_cmd,
  input wire logic low_side_cmd,
  input wire logic stage_enable_cmd,
  output logic high_side_gate_out,
  output logic low_side_gate_out,
  input wire logic [MARGIN_WIDTH-1:0] margin_high_ratio_level,
  input wire logic [MARGIN_WIDTH-1:0] margin_low_ratio_level,
  input wire logic [MARGIN_WIDTH-1:0] margin_high_fixed_level,
  input wire logic [MARGIN_WIDTH-1:0] margin_low_fixed_level,
  output logic [MARGIN_WIDTH-1:0] margin_high_level,
  output logic [MARGIN_WIDTH-1:0] margin_low_level,
  input wire logic power_good_status,
  output logic power_good_out,
  output logic power_good_oe,
  output logic external_temp_sensor_en,
  input wire logic [TEMP_WIDTH-1:0] internal_temp,
  input wire logic [TEMP_WIDTH-1:0] external_temp_sensor,
  output logic [TEMP_WIDTH-1:0] fault_temp,
  output user_feature_config_pkg::linear11_type sense_impedance
);

  initial begin
    if (TEMP_WIDTH < 1 || MARGIN_WIDTH < 1) begin
      $error("Widths must be at least one bit");
    end
  end

  logic [15:0] feature_reg;
  logic [15:0] feature_next;
  logic [15:0] cal_gain_reg;
  logic [15:0] cal_gain_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic unsupported_reg;
  logic unsupported_next;
  logic [user_feature_config_pkg::DUTY_WIDTH-1:0] duty_reg;
  logic high_reg;
  logic low_reg;
  logic [MARGIN_WIDTH-1:0] margin_high_reg;
  logic [MARGIN_WIDTH-1:0] margin_low_reg;
  logic pg_out_reg;
  logic pg_oe_reg;
  logic [TEMP_WIDTH-1:0] fault_temp_reg;
  user_feature_config_pkg::feature_fields_type feat;
  user_feature_config_pkg::linear11_type cal_fields;
  user_feature_config_pkg::linear11_type impedance_reg;

  // Command decode
  wire hit_feature = cmd_code == user_feature_config_pkg::CMD_USER_FEATURE_CONFIG;
  wire hit_cal = cmd_code == user_feature_config_pkg::CMD_INPUT_CURRENT_CAL_GAIN;
  wire hit_any = hit_feature | hit_cal;
  // Protected writes are dropped silently, as the bus layer flags them itself
  wire write_ok = cmd_write & ~write_protect;

  // Unused bits are stored and echoed, never acted on
  assign feature_next = (write_ok && hit_feature) ? cmd_wdata : feature_reg; // [RQ9] [RQ13]
  assign cal_gain_next = (write_ok && hit_cal) ? cmd_wdata : cal_gain_reg; // [RQ12]
  assign rdata_next = !cmd_read ? rdata_reg :
                      hit_feature ? feature_reg :
                      hit_cal ? cal_gain_reg : 16'h0000;
  assign unsupported_next = (cmd_read | cmd_write) & ~hit_any;

  // Field extraction
  assign feat.min_duty_code = feature_reg[user_feature_config_pkg::MIN_DUTY_MSB:
                                          user_feature_config_pkg::MIN_DUTY_LSB];
  assign feat.driver_stage_mode = feature_reg[user_feature_config_pkg::DRIVER_STAGE_BIT];
  assign feat.min_duty_en = feature_reg[user_feature_config_pkg::MIN_DUTY_EN_BIT];
  assign feat.margin_ratio_en = feature_reg[user_feature_config_pkg::MARGIN_RATIO_EN_BIT];
  assign feat.pg_push_pull = feature_reg[user_feature_config_pkg::PG_PUSH_PULL_BIT];
  assign feat.ext_temp_en = feature_reg[user_feature_config_pkg::EXT_TEMP_EN_BIT];
  assign feat.ext_temp_fault_sel = feature_reg[user_feature_config_pkg::EXT_TEMP_FAULT_BIT];

  // Floor in 1/512 units is 2*(code+1); at most 64 so nine bits suffice
  wire [user_feature_config_pkg::DUTY_WIDTH-1:0] min_duty =
    {3'h0, feat.min_duty_code, 1'b0} + 9'h002; // [RQ1]
  wire clamp_active = feat.min_duty_en && (duty_request < min_duty); // [RQ2]
  wire [user_feature_config_pkg::DUTY_WIDTH-1:0] duty_sel =
    clamp_active ? min_duty : duty_request; // [RQ2]

  // Gate pin roles
  wire high_sel = high_side_cmd; // [RQ3] [RQ4]
  wire low_sel = feat.driver_stage_mode ? stage_enable_cmd : low_side_cmd; // [RQ3] [RQ4]

  // Margin source
  wire [MARGIN_WIDTH-1:0] margin_high_sel =
    feat.margin_ratio_en ? margin_high_ratio_level : margin_high_fixed_level; // [RQ5]
  wire [MARGIN_WIDTH-1:0] margin_low_sel =
    feat.margin_ratio_en ? margin_low_ratio_level : margin_low_fixed_level; // [RQ5]

  // Open-drain only pulls low; push-pull drives both levels
  wire pg_out_sel = feat.pg_push_pull ? power_good_status : 1'b0; // [RQ6]
  wire pg_oe_sel = feat.pg_push_pull | ~power_good_status; // [RQ6]

  wire [TEMP_WIDTH-1:0] temp_sel =
    feat.ext_temp_fault_sel ? external_temp_sensor : internal_temp; // [RQ8]

  linear11_unpack cal_unpack (
    .word(cal_gain_reg),
    .fields(cal_fields)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      feature_reg <= user_feature_config_pkg::USER_FEATURE_CONFIG_RESET; // [RQ9]
      cal_gain_reg <= user_feature_config_pkg::INPUT_CURRENT_CAL_GAIN_RESET; // [RQ12]
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      unsupported_reg <= 1'b0;
    end else begin
      feature_reg <= feature_next;
      cal_gain_reg <= cal_gain_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= cmd_read;
      unsupported_reg <= unsupported_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      duty_reg <= '0;
      high_reg <= 1'b0;
      low_reg <= 1'b0;
      margin_high_reg <= '0;
      margin_low_reg <= '0;
      pg_out_reg <= 1'b0;
      pg_oe_reg <= 1'b1;
      fault_temp_reg <= '0;
      // Mirrors the reset word so the current path sees the default gain at once
      impedance_reg <= user_feature_config_pkg::INPUT_CURRENT_CAL_GAIN_RESET; // [RQ11]
    end else begin
      duty_reg <= duty_sel;
      high_reg <= high_sel;
      low_reg <= low_sel;
      margin_high_reg <= margin_high_sel;
      margin_low_reg <= margin_low_sel;
      pg_out_reg <= pg_out_sel;
      pg_oe_reg <= pg_oe_sel;
      fault_temp_reg <= temp_sel;
      impedance_reg <= cal_fields; // [RQ11]
    end
  end

  assign cmd_rdata = rdata_reg;
  assign cmd_rvalid = rvalid_reg;
  assign cmd_unsupported = unsupported_reg;
  assign duty_applied = duty_reg;
  assign high_side_gate_out = high_reg;
  assign low_side_gate_out = low_reg;
  assign margin_high_level = margin_high_reg;
  assign margin_low_level = margin_low_reg;
  assign power_good_out = pg_out_reg;
  assign power_good_oe = pg_oe_reg;
  assign external_temp_sensor_en = feat.ext_temp_en; // [RQ7]
  assign fault_temp = fault_temp_reg;
  // Impedance in milliohms at 25 C for the input-current computation
  assign sense_impedance = impedance_reg; // [RQ11]

endmodule

// ### testbench/user_feature_config_regs_asserts.sv
// Checker: port-level properties of the feature registers
`timescale 1ns/1ps
module user_feature_config_regs_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_wdata,
  input wire logic write_protect,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_unsupported,
  input wire logic [user_feature_config_pkg::DUTY_WIDTH-1:0] duty_request,
  input wire logic [user_feature_config_pkg::DUTY_WIDTH-1:0] duty_applied,
  input wire logic high_side_cmd,
  input wire logic high_side_gate_out,
  input wire logic power_good_status,
  input wire logic power_good_out,
  input wire logic power_good_oe,
  input wire logic external_temp_sensor_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rvalid; 1 |=> cmd_rvalid == $past(cmd_read); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer late or spurious");
  property p_unsup; cmd_read && !(cmd_code inside {8'hd1, 8'hd2}) |=> cmd_unsupported && cmd_rdata == 16'h0000; endproperty
  a_unsup: assert property (p_unsup) else $error("unknown code not refused");
  property p_known; cmd_read && cmd_code == 8'hd1 |=> !cmd_unsupported; endproperty
  a_known: assert property (p_known) else $error("known code refused");
  property p_ext_wr; cmd_write && !write_protect && cmd_code == 8'hd1 |=> external_temp_sensor_en == $past(cmd_wdata[1]); endproperty
  a_ext_wr: assert property (p_ext_wr) else $error("sensor enable not from bit 1");
  // Protected writes must leave the external sensor enable untouched
  property p_wp; cmd_write && write_protect |=> $stable(external_temp_sensor_en); endproperty
  a_wp: assert property (p_wp) else $error("protected write took effect");
  property p_duty_lo; 1 |=> duty_applied >= $past(duty_request); endproperty
  a_duty_lo: assert property (p_duty_lo) else $error("duty lowered");
  property p_duty_hi; 1 |=> duty_applied <= $past(duty_request) || duty_applied <= 9'h040; endproperty
  a_duty_hi: assert property (p_duty_hi) else $error("duty floor too high");
  property p_gate; 1 |=> high_side_gate_out == $past(high_side_cmd); endproperty
  a_gate: assert property (p_gate) else $error("high gate wrong");
  property p_pg; 1 |=> (power_good_oe && power_good_out == $past(power_good_status)) || (!power_good_out && power_good_oe == !$past(power_good_status)); endproperty
  a_pg: assert property (p_pg) else $error("power good drive wrong");
endmodule
bind user_feature_config_regs user_feature_config_regs_asserts i_chk (.*);

// ### testbench/pg_board_model.sv
// Board model: pull-up on the power-good net
`timescale 1ns/1ps
module pg_board_model (
  input wire logic pg_drive,
  input wire logic pg_oe,
  output logic pg_net
);
  // Undriven net floats to the pull-up, never to the last level
  assign pg_net = pg_oe ? pg_drive : 1'b1;
endmodule

// ### testbench/user_feature_config_regs_bench.sv
// Bench: reset values, access and field effects of the feature registers
`timescale 1ns/1ps
module user_feature_config_regs_bench;
  logic sys_clk, rst, cmd_write, cmd_read, write_protect, cmd_rvalid, cmd_unsupported;
  logic high_side_cmd, low_side_cmd, stage_enable_cmd, high_side_gate_out, low_side_gate_out;
  logic power_good_status, power_good_out, power_good_oe, external_temp_sensor_en, pg_net;
  logic [7:0] cmd_code;
  logic [8:0] duty_request, duty_applied;
  logic [15:0] cmd_wdata, cmd_rdata, margin_high_ratio_level, margin_low_ratio_level;
  logic [15:0] margin_high_fixed_level, margin_low_fixed_level, margin_high_level;
  logic [15:0] margin_low_level, internal_temp, external_temp_sensor, fault_temp;
  user_feature_config_pkg::linear11_type sense_impedance;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  user_feature_config_regs i_dut (.*);
  pg_board_model i_board (.pg_drive(power_good_out), .pg_oe(power_good_oe), .pg_net(pg_net));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk);
    cmd_code <= c;
    cmd_wdata <= d;
    cmd_write <= 1'b1;
    @(posedge sys_clk);
    cmd_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    @(posedge sys_clk);
    cmd_code <= c;
    cmd_read <= 1'b1;
    @(posedge sys_clk);
    cmd_read <= 1'b0;
    #1;
    chk("rdata", exp, cmd_rdata);
  endtask
  task automatic t_regs();
    rd(8'hd1, 16'h0402);
    rd(8'hd2, 16'hc200);
    chk("sense", 16'hc200, sense_impedance);
    chk("temp_en", 16'h0001, 16'(external_temp_sensor_en));
    wr(8'hd1, 16'hffff);
    rd(8'hd1, 16'hffff);
    @(posedge sys_clk);
    write_protect <= 1'b1;
    wr(8'hd1, 16'h0000);
    write_protect <= 1'b0;
    rd(8'hd1, 16'hffff);
    wr(8'hd2, 16'hf805);
    rd(8'hd2, 16'hf805);
    chk("sense", 16'hf805, sense_impedance);
    rd(8'hd3, 16'h0000);
    chk("unsupported", 16'h0001, 16'(cmd_unsupported));
  endtask
  task automatic t_duty();
    wr(8'hd1, 16'h1880);
    step(2);
    chk("duty", 16'h0008, 16'(duty_applied));
    wr(8'hd1, 16'hf880);
    duty_request <= 9'h03f;
    step(2);
    chk("duty", 16'h0040, 16'(duty_applied));
    wr(8'hd1, 16'h7800);
    step(2);
    chk("duty", 16'h003f, 16'(duty_applied));
  endtask
  task automatic t_select();
    wr(8'hd1, 16'h0015);
    step(2);
    chk("low_gate", 16'h0000, 16'(low_side_gate_out));
    chk("high_gate", 16'h0001, 16'(high_side_gate_out));
    chk("margin", 16'h1111, margin_high_level);
    chk("margin_low", 16'h3333, margin_low_level);
    chk("fault_temp", 16'h0044, fault_temp);
    chk("pg_oe", 16'h0001, 16'(power_good_oe));
    chk("pg_out", 16'h0001, 16'(power_good_out));
    wr(8'hd1, 16'h0400);
    step(2);
    chk("low_gate", 16'h0001, 16'(low_side_gate_out));
    chk("margin", 16'h2222, margin_high_level);
    chk("margin_low", 16'h4444, margin_low_level);
    chk("fault_temp", 16'h0033, fault_temp);
    chk("pg_oe", 16'h0000, 16'(power_good_oe));
    chk("pg_net", 16'h0001, 16'(pg_net));
    chk("temp_en", 16'h0000, 16'(external_temp_sensor_en));
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Ceiling is far above the fifty-odd cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {cmd_write, cmd_read, write_protect, low_side_cmd} = 4'h0;
    {high_side_cmd, stage_enable_cmd, power_good_status, rst} = 4'hf;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    duty_request = 9'h002;
    margin_high_ratio_level = 16'h1111;
    margin_high_fixed_level = 16'h2222;
    margin_low_ratio_level = 16'h3333;
    margin_low_fixed_level = 16'h4444;
    internal_temp = 16'h0033;
    external_temp_sensor = 16'h0044;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_duty();
    t_select();
    end_sim();
  end
endmodule
